// *** logic/reg_set_core.sv ***
`timescale 1ns/10ps
`default_nettype none
module reg_set_core
    import reg_set_pkg::*;
#(
    parameter int GEN_COUNT = NUM_GEN,
    parameter int FLT_COUNT = NUM_FLT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire wr_req_t wr_i,
    input wire rd_req_t rd_a_i,
    input wire rd_req_t rd_b_i,
    input wire xfer_req_t xfer_i,
    input wire logic mac_we_i,
    input wire logic [2*DATA_W-1:0] mac_result_i,
    input wire logic call_i,
    input wire logic [DATA_W-1:0] call_target_i,
    input wire logic pc_step_i,
    input wire logic exc_push_i,
    input wire logic exc_pop_i,
    input wire logic [DATA_W-1:0] gbr_disp_i,
    input wire logic [VEC_NUM_W-1:0] vec_num_i,
    input wire logic [FLOAT_STATUS_CONTROL_REG_FLAG_W-1:0] fpu_flags_i,
    input wire logic vec_ack_i,
    input wire logic [DATA_W-1:0] vec_data_i,
    output logic [DATA_W-1:0] rd_a_o,
    output logic [DATA_W-1:0] rd_b_o,
    output logic [DATA_W-1:0] index_o,
    output logic [DATA_W-1:0] flt_index_o,
    output logic [DATA_W-1:0] stack_addr_o,
    output logic [DATA_W-1:0] gbr_addr_o,
    output logic [DATA_W-1:0] vec_entry_addr_o,
    output logic [DATA_W-1:0] pc_o,
    output logic [DATA_W-1:0] sr_o,
    output logic [DATA_W-1:0] float_status_control_reg_o,
    output logic vec_req_o,
    output logic [DATA_W-1:0] vec_addr_o,
    output logic ready_o
);
    // the register numbering is architectural; other sizes cannot be decoded
    if (GEN_COUNT != NUM_GEN || FLT_COUNT != NUM_FLT) $error("register counts must be sixteen");

    // ****************************************
    // architectural state
    // ****************************************
    logic [DATA_W-1:0] general_reg [GEN_COUNT];
    logic [DATA_W-1:0] float_data_regs [FLT_COUNT];
    logic [DATA_W-1:0] status_reg;
    logic [DATA_W-1:0] global_base_reg;
    logic [DATA_W-1:0] vector_base_reg;
    logic [DATA_W-1:0] mac_high_reg;
    logic [DATA_W-1:0] mac_low_reg;
    logic [DATA_W-1:0] return_address_reg;
    logic [DATA_W-1:0] program_counter;
    logic [DATA_W-1:0] float_transfer_reg;
    logic [DATA_W-1:0] float_status_control_reg;
    logic [DATA_W-1:0] load_word;

    typedef enum logic [1:0] {VF_PC, VF_SP, VF_DONE} vec_state_t;
    vec_state_t vec_state_reg;
    logic boot_done;

    assign boot_done = (vec_state_reg == VF_DONE);

    // ****************************************
    // operand widening
    // ****************************************
    load_extend u_load_extend (
        .size_i(wr_i.size),
        .raw_i(wr_i.data),
        .word_o(load_word)
    );

    function automatic logic wr_hits(input reg_sel_t sel);
        return wr_i.en && boot_done && wr_i.sel == sel;
    endfunction

    // ****************************************
    // reset vector fetch
    // ****************************************
    // every architectural register but the float exception flags and the program counter, loaded from the first entry, holds still until both entries are in
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            vec_state_reg <= VF_PC;
        end else if (vec_ack_i) begin
            unique case (vec_state_reg)
                VF_PC: vec_state_reg <= VF_SP;
                VF_SP: vec_state_reg <= VF_DONE;
                VF_DONE: vec_state_reg <= VF_DONE;
            endcase
        end
    end

    // request stays up between entries, so a pair of acks can come back to back
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            vec_req_o <= 1'b1;
            vec_addr_o <= VBR_RST + VEC_PC_OFS;
            ready_o <= 1'b0;
        end else begin
            if (vec_ack_i && vec_state_reg == VF_PC) begin
                vec_addr_o <= VBR_RST + VEC_SP_OFS;
            end
            if (vec_ack_i && vec_state_reg == VF_SP) begin
                vec_req_o <= 1'b0;
                ready_o <= 1'b1;
            end
        end
    end

    // ****************************************
    // general registers
    // ****************************************
    // stack moves outrank software writes; data words are never reset
    always_ff @(posedge clk_i) begin
        if (!rst_i && vec_ack_i && vec_state_reg == VF_SP) begin
            general_reg[IDX_STACK] <= vec_data_i;
        end else if (!rst_i && boot_done) begin
            if (wr_hits(SEL_GEN)) begin
                general_reg[wr_i.idx] <= load_word;
            end else if (xfer_i.en && !xfer_i.to_fpu) begin
                general_reg[xfer_i.idx] <= float_transfer_reg;
            end
            if (exc_push_i) begin
                general_reg[IDX_STACK] <= general_reg[IDX_STACK] - STACK_STEP;
            end else if (exc_pop_i) begin
                general_reg[IDX_STACK] <= general_reg[IDX_STACK] + STACK_STEP;
            end
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_reg <= SR_RST;
        end else if (wr_hits(SEL_SR)) begin
            status_reg <= wr_i.data & SR_VALID_MASK;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            vector_base_reg <= VBR_RST;
        end else if (wr_hits(SEL_VBR)) begin
            vector_base_reg <= wr_i.data;
        end
    end

    // global base has no defined reset value
    always_ff @(posedge clk_i) begin
        if (!rst_i && wr_hits(SEL_GBR)) begin
            global_base_reg <= wr_i.data;
        end
    end

    // ****************************************
    // system registers
    // ****************************************
    // a full product arrives as one 64-bit word and lands in both halves
    always_ff @(posedge clk_i) begin
        if (!rst_i && boot_done && mac_we_i) begin
            mac_high_reg <= mac_result_i[2*DATA_W-1:DATA_W];
            mac_low_reg <= mac_result_i[DATA_W-1:0];
        end else begin
            if (wr_hits(SEL_MAC_HIGH_REG)) begin
                mac_high_reg <= wr_i.data;
            end
            if (wr_hits(SEL_MAC_LOW_REG)) begin
                mac_low_reg <= wr_i.data;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_i && boot_done && call_i) begin
            return_address_reg <= program_counter;
        end else if (wr_hits(SEL_PR)) begin
            return_address_reg <= wr_i.data;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            program_counter <= '0;
        end else if (vec_ack_i && vec_state_reg == VF_PC) begin
            program_counter <= vec_data_i;
        end else if (boot_done) begin
            if (call_i) begin
                program_counter <= call_target_i;
            end else if (wr_hits(SEL_PC)) begin
                program_counter <= wr_i.data;
            end else if (pc_step_i) begin
                program_counter <= program_counter + INSN_STEP;
            end
        end
    end

    // ****************************************
    // floating-point registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (wr_hits(SEL_FR)) begin
            float_data_regs[wr_i.idx] <= wr_i.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_i && boot_done && xfer_i.en && xfer_i.to_fpu) begin
            float_transfer_reg <= general_reg[xfer_i.idx];
        end else if (wr_hits(SEL_FLOAT_TRANSFER_REG)) begin
            float_transfer_reg <= wr_i.data;
        end
    end

    // exception flags are sticky; a new flag survives a same-cycle write
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            float_status_control_reg <= FLOAT_STATUS_CONTROL_REG_RST;
        end else begin
            float_status_control_reg <= (wr_hits(SEL_FLOAT_STATUS_CONTROL_REG) ? wr_i.data
                : float_status_control_reg)
                | ({{(DATA_W-FLOAT_STATUS_CONTROL_REG_FLAG_W){1'b0}}, fpu_flags_i} << FLOAT_STATUS_CONTROL_REG_FLAG_LSB);
        end
    end

    // ****************************************
    // read ports
    // ****************************************
    function automatic logic [DATA_W-1:0] read_reg(input rd_req_t r);
        unique case (r.sel)
            SEL_GEN: return general_reg[r.idx];
            SEL_SR: return status_reg;
            SEL_GBR: return global_base_reg;
            SEL_VBR: return vector_base_reg;
            SEL_MAC_HIGH_REG: return mac_high_reg;
            SEL_MAC_LOW_REG: return mac_low_reg;
            SEL_PR: return return_address_reg;
            SEL_PC: return program_counter;
            SEL_FR: return float_data_regs[r.idx];
            SEL_FLOAT_TRANSFER_REG: return float_transfer_reg;
            SEL_FLOAT_STATUS_CONTROL_REG: return float_status_control_reg;
            default: return '0;
        endcase
    endfunction

    // one cycle of latency keeps every output on a flip-flop
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_a_o <= '0;
            rd_b_o <= '0;
        end else begin
            rd_a_o <= read_reg(rd_a_i);
            rd_b_o <= read_reg(rd_b_i);
        end
    end

    // ****************************************
    // dedicated operand taps
    // ****************************************
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            index_o <= '0;
            flt_index_o <= '0;
            stack_addr_o <= '0;
            gbr_addr_o <= '0;
            vec_entry_addr_o <= '0;
            pc_o <= '0;
            sr_o <= SR_RST;
            float_status_control_reg_o <= FLOAT_STATUS_CONTROL_REG_RST;
        end else begin
            index_o <= general_reg[IDX_INDEX];
            flt_index_o <= float_data_regs[0];
            stack_addr_o <= general_reg[IDX_STACK];
            gbr_addr_o <= global_base_reg + gbr_disp_i;
            vec_entry_addr_o <= vector_base_reg
                + {{(DATA_W-VEC_NUM_W-2){1'b0}}, vec_num_i, 2'b00};
            pc_o <= program_counter;
            sr_o <= status_reg;
            float_status_control_reg_o <= float_status_control_reg;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_sr_mask;
        $fell(rst_i) |-> status_reg[SR_IMASK_LSB +: SR_IMASK_W] == SR_IMASK_RST
            && (status_reg & ~SR_VALID_MASK) == '0;
    endproperty
    a_sr_mask: assert property (p_sr_mask) else $error("mask bits not set");
    property p_sr_rsvd;
        (status_reg & ~SR_VALID_MASK) == '0;
    endproperty
    a_sr_rsvd: assert property (p_sr_rsvd) else $error("reserved bits set");
    property p_vbr_clear;
        !boot_done |-> vector_base_reg == VBR_RST;
    endproperty
    a_vbr_clear: assert property (p_vbr_clear) else $error("vector base not zero");

    property p_float_status_control_reg_init;
        (vec_state_reg == VF_PC && fpu_flags_i == '0 && !$past(vec_ack_i))
            |-> float_status_control_reg == FLOAT_STATUS_CONTROL_REG_RST;
    endproperty
    a_float_status_control_reg_init: assert property (p_float_status_control_reg_init) else $error("float_status_control_reg reset wrong");

    property p_pc_vec;
        vec_ack_i && vec_state_reg == VF_PC |=> program_counter == $past(vec_data_i)
            && vec_addr_o == VBR_RST + VEC_SP_OFS;
    endproperty
    a_pc_vec: assert property (p_pc_vec) else $error("pc not loaded");

    property p_sp_vec;
        vec_ack_i && vec_state_reg == VF_SP |=> general_reg[IDX_STACK] == $past(vec_data_i)
            ##1 ready_o && !vec_req_o;
    endproperty
    a_sp_vec: assert property (p_sp_vec) else $error("stack pointer not loaded");

    property p_push;
        boot_done && exc_push_i |=> general_reg[IDX_STACK]
            == $past(general_reg[IDX_STACK]) - STACK_STEP ##1 stack_addr_o
            == $past(general_reg[IDX_STACK]);
    endproperty
    a_push: assert property (p_push) else $error("push did not step");
    property p_mac;
        boot_done && mac_we_i |=> {mac_high_reg, mac_low_reg} == $past(mac_result_i);
    endproperty
    a_mac: assert property (p_mac) else $error("mac pair wrong");

    property p_call;
        boot_done && call_i |=> return_address_reg == $past(program_counter)
            && program_counter == $past(call_target_i);
    endproperty
    a_call: assert property (p_call) else $error("call return wrong");

    property p_sext_byte;
        boot_done && wr_i.en && wr_i.sel == SEL_GEN && wr_i.size == SZ_BYTE
            && !exc_push_i && !exc_pop_i && !(vec_ack_i && !boot_done)
            |=> general_reg[$past(wr_i.idx)] == {{24{$past(wr_i.data[7])}}, $past(wr_i.data[7:0])};
    endproperty
    a_sext_byte: assert property (p_sext_byte) else $error("byte not extended");

    property p_float_transfer_reg;
        boot_done && xfer_i.en && xfer_i.to_fpu
            |=> float_transfer_reg == $past(general_reg[xfer_i.idx]);
    endproperty
    a_float_transfer_reg: assert property (p_float_transfer_reg) else $error("transfer lost");

    property p_flag_sticky;
        fpu_flags_i != '0 |=> (float_status_control_reg[FLOAT_STATUS_CONTROL_REG_FLAG_LSB +: FLOAT_STATUS_CONTROL_REG_FLAG_W]
            & $past(fpu_flags_i)) == $past(fpu_flags_i);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");
    property p_index_tap;
        boot_done && wr_i.en && wr_i.sel == SEL_GEN && wr_i.idx == IDX_INDEX
            |=> ##1 index_o == $past(general_reg[IDX_INDEX]);
    endproperty
    a_index_tap: assert property (p_index_tap) else $error("index tap stale");
    property p_flt_index_tap;
        boot_done && wr_i.en && wr_i.sel == SEL_FR && wr_i.idx == '0
            |=> ##1 flt_index_o == $past(float_data_regs[0]);
    endproperty
    a_flt_index_tap: assert property (p_flt_index_tap) else $error("float index tap stale");
endmodule
`default_nettype wire

// *** logic/reg_set_pkg.sv ***
//Contract
//- sixteen 32-bit general registers, numbered 0-15
//- three control, four system registers kept separately
//- register zero is index and fixed operand
//- register fifteen is stack pointer for exceptions
//- global base added for base-relative addressing
//- vector base locates exception vector area
//- high/low mac registers hold multiply results
//- return address and program counter held
//- sixteen float data plus two float system
//- float register zero indexes float multiply-accumulate
//- float transfer register moves core/float values
//- float status/control records float exceptions
//- reset: mask bits ones, reserved bits zero
//- reset: stack pointer loaded from vector table
//- reset: program counter loaded from vector table
//- register operands are always full 32 bits
//- byte and halfword loads sign-extended
package reg_set_pkg;
    localparam int DATA_W = 32;
    localparam int NUM_GEN = 16;
    localparam int NUM_FLT = 16;
    localparam int IDX_W = 4;
    localparam logic [IDX_W-1:0] IDX_INDEX = 4'h0;
    localparam logic [IDX_W-1:0] IDX_STACK = 4'hf;
    // status register layout
    localparam int SR_IMASK_LSB = 4;
    localparam int SR_IMASK_W = 4;
    localparam logic [3:0] SR_IMASK_RST = 4'hf;
    localparam logic [31:0] SR_VALID_MASK = 32'h000003f3;
    localparam logic [31:0] SR_RST = 32'h000000f0;
    localparam logic [31:0] VBR_RST = 32'h00000000;
    localparam logic [31:0] FLOAT_STATUS_CONTROL_REG_RST = 32'h00040001;
    localparam int FLOAT_STATUS_CONTROL_REG_FLAG_LSB = 2;
    localparam int FLOAT_STATUS_CONTROL_REG_FLAG_W = 5;
    // vector table entries, relative to the vector base
    localparam logic [31:0] VEC_PC_OFS = 32'h00000000;
    localparam logic [31:0] VEC_SP_OFS = 32'h00000004;
    localparam logic [31:0] STACK_STEP = 32'h00000004;
    localparam logic [31:0] INSN_STEP = 32'h00000002;
    localparam int VEC_NUM_W = 8;

    typedef enum logic [3:0] {
        SEL_GEN, SEL_SR, SEL_GBR, SEL_VBR, SEL_MAC_HIGH_REG, SEL_MAC_LOW_REG,
        SEL_PR, SEL_PC, SEL_FR, SEL_FLOAT_TRANSFER_REG, SEL_FLOAT_STATUS_CONTROL_REG
    } reg_sel_t;

    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_LONG} load_size_t;

    typedef struct packed {
        logic en;
        reg_sel_t sel;
        logic [IDX_W-1:0] idx;
        load_size_t size;
        logic [DATA_W-1:0] data;
    } wr_req_t;

    typedef struct packed {
        reg_sel_t sel;
        logic [IDX_W-1:0] idx;
    } rd_req_t;

    typedef struct packed {
        logic en;
        logic to_fpu;
        logic [IDX_W-1:0] idx;
    } xfer_req_t;
endpackage

// *** logic/load_extend.sv ***
`timescale 1ns/10ps
`default_nettype none
// widens a narrow memory operand to a full register word
module load_extend
    import reg_set_pkg::*;
(
    input wire load_size_t size_i,
    input wire logic [DATA_W-1:0] raw_i,
    output logic [DATA_W-1:0] word_o
);
    // sign bit of the operand fills every upper bit
    always_comb begin
        unique case (size_i)
            SZ_BYTE: word_o = {{(DATA_W-8){raw_i[7]}}, raw_i[7:0]};
            SZ_HALF: word_o = {{(DATA_W-16){raw_i[15]}}, raw_i[15:0]};
            default: word_o = raw_i;
        endcase
    end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
// one compare: counts it, reports a mismatch at once
`define CHK(got, want, code) begin comparisons++; if ((got) !== (want)) begin bad_count++; \
    $display("BAD %0t output %0d got %h want %h", $time, code, got, want); end end
module testbench
    import reg_set_pkg::*;
;
    // ****************************************
    // stimulus and observation signals
    // ****************************************
    typedef struct {int due; int code; logic [DATA_W-1:0] val;} exp_t;
    logic clk_i, rst_i, mac_we_i, call_i, pc_step_i, exc_push_i, exc_pop_i, vec_ack_i;
    wr_req_t wr_i;
    rd_req_t rd_a_i, rd_b_i;
    xfer_req_t xfer_i;
    logic [2*DATA_W-1:0] mac_result_i;
    logic [DATA_W-1:0] call_target_i, gbr_disp_i, vec_data_i;
    logic [VEC_NUM_W-1:0] vec_num_i;
    logic [FLOAT_STATUS_CONTROL_REG_FLAG_W-1:0] fpu_flags_i;
    logic [DATA_W-1:0] rd_a_o, rd_b_o, index_o, flt_index_o, stack_addr_o, gbr_addr_o;
    logic [DATA_W-1:0] vec_entry_addr_o, pc_o, sr_o, float_status_control_reg_o, vec_addr_o;
    logic vec_req_o, ready_o;
    int bad_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int seed = 32'hfa49;
    exp_t q[$];
    exp_t e;

    reg_set_core dut (.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_a_i(rd_a_i),
        .rd_b_i(rd_b_i), .xfer_i(xfer_i), .mac_we_i(mac_we_i), .mac_result_i(mac_result_i),
        .call_i(call_i), .call_target_i(call_target_i), .pc_step_i(pc_step_i),
        .exc_push_i(exc_push_i), .exc_pop_i(exc_pop_i), .gbr_disp_i(gbr_disp_i),
        .vec_num_i(vec_num_i), .fpu_flags_i(fpu_flags_i), .vec_ack_i(vec_ack_i),
        .vec_data_i(vec_data_i), .rd_a_o(rd_a_o), .rd_b_o(rd_b_o), .index_o(index_o),
        .flt_index_o(flt_index_o), .stack_addr_o(stack_addr_o), .gbr_addr_o(gbr_addr_o),
        .vec_entry_addr_o(vec_entry_addr_o), .pc_o(pc_o), .sr_o(sr_o), .float_status_control_reg_o(float_status_control_reg_o),
        .vec_req_o(vec_req_o), .vec_addr_o(vec_addr_o), .ready_o(ready_o));

    // clock at 8 ns
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // ****************************************
    // result watcher
    // ****************************************
    function automatic logic [DATA_W-1:0] pick(int code);
        case (code)
            0: return rd_a_o;
            1: return rd_b_o;
            2: return index_o;
            3: return flt_index_o;
            4: return stack_addr_o;
            5: return gbr_addr_o;
            6: return vec_entry_addr_o;
            7: return pc_o;
            8: return sr_o;
            9: return float_status_control_reg_o;
            10: return 32'(vec_req_o);
            11: return vec_addr_o;
            default: return 32'(ready_o);
        endcase
    endfunction

    // sees values settled by the previous edge, since cyc and the design update late
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        while (q.size() > 0 && q[0].due == cyc) begin
            e = q.pop_front();
            `CHK(pick(e.code), e.val, e.code)
        end
    end

    task automatic test_done;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // a hang anywhere ends the run as a mismatch
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        test_done();
    end

    // ****************************************
    // driver tasks
    // ****************************************
    task automatic step;
        @(posedge clk_i);
    endtask

    // expectations must be pushed in order of due cycle
    task automatic put(int code, logic [DATA_W-1:0] v, int d);
        q.push_back('{cyc + d, code, v});
    endtask

    function automatic logic [DATA_W-1:0] ext(load_size_t z, logic [DATA_W-1:0] d);
        case (z)
            SZ_BYTE: return {{24{d[7]}}, d[7:0]};
            SZ_HALF: return {{16{d[15]}}, d[15:0]};
            default: return d;
        endcase
    endfunction

    // write one register, then read it back on port a (0) or b (1)
    task automatic wrd(reg_sel_t s, logic [3:0] x, load_size_t z, logic [DATA_W-1:0] d,
            logic [DATA_W-1:0] want, int port);
        step();
        wr_i <= '{1'b1, s, x, z, d};
        step();
        wr_i.en <= 1'b0;
        if (port == 0) rd_a_i <= '{s, x};
        else rd_b_i <= '{s, x};
        put(port, want, 2);
    endtask

    task automatic do_reset;
        rst_i <= 1'b1;
        repeat (10) step();
        put(8, SR_RST, 1);
        put(9, FLOAT_STATUS_CONTROL_REG_RST, 1);
        put(10, 32'h1, 1);
        put(12, 32'h0, 1);
        repeat (10) step();
        rst_i <= 1'b0;
    endtask

    // vector fetch with a refused early write and a late stray answer
    task automatic fetch(logic [DATA_W-1:0] p, logic [DATA_W-1:0] s);
        int n;
        for (n = 0; n < 10 && vec_req_o !== 1'b1; n++) step();
        if (n == 10) begin
            bad_count++;
            test_done();
        end
        step();
        put(11, VEC_PC_OFS, 1);
        put(11, VEC_SP_OFS, 2);
        wr_i <= '{1'b1, SEL_VBR, 4'h0, SZ_LONG, 32'h00000100};
        vec_ack_i <= 1'b1;
        vec_data_i <= p;
        step();
        wr_i.en <= 1'b0;
        vec_data_i <= s;
        put(7, p, 2);
        put(12, 32'h1, 2);
        put(10, 32'h0, 2);
        put(4, s, 3);
        step();
        vec_ack_i <= 1'b0;
        put(6, {22'h0, vec_num_i, 2'b00}, 3);
        step();
        vec_ack_i <= 1'b1;
        vec_data_i <= ~p;
        step();
        vec_ack_i <= 1'b0;
        put(7, p, 3);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [DATA_W-1:0] v[16];
        logic [DATA_W-1:0] d, pcv, t;
        logic [2*DATA_W-1:0] m;
        logic [FLOAT_STATUS_CONTROL_REG_FLAG_W-1:0] f;
        reg_sel_t sels[10];
        sels = '{SEL_SR, SEL_GBR, SEL_VBR, SEL_MAC_HIGH_REG, SEL_MAC_LOW_REG, SEL_PR, SEL_PC, SEL_FR,
            SEL_FLOAT_TRANSFER_REG, SEL_FLOAT_STATUS_CONTROL_REG};
        rst_i = 1'b1;
        wr_i = '0;
        rd_a_i = '0;
        rd_b_i = '0;
        xfer_i = '0;
        {mac_we_i, call_i, pc_step_i, exc_push_i, exc_pop_i, vec_ack_i} = 6'h00;
        mac_result_i = '0;
        call_target_i = '0;
        gbr_disp_i = '0;
        vec_data_i = '0;
        vec_num_i = 8'h05;
        fpu_flags_i = '0;
        do_reset();
        fetch(32'h00001000, 32'h0000fff0);
        // all sixteen general registers, written back to back
        for (int i = 0; i < 16; i++) begin
            step();
            v[i] = $random(seed);
            wr_i <= '{1'b1, SEL_GEN, 4'(i), SZ_LONG, v[i]};
        end
        step();
        wr_i.en <= 1'b0;
        put(2, v[0], 2);
        put(4, v[15], 2);
        for (int i = 0; i < 16; i++) begin
            rd_a_i <= '{SEL_GEN, 4'(i)};
            put(0, v[i], 2);
            step();
        end
        // narrow loads, both signs of the top bit
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            d[7] = (i < 3);
            d[15] = (i < 3);
            wrd(SEL_GEN, 4'h3, load_size_t'(i % 3), d, ext(load_size_t'(i % 3), d), 0);
        end
        for (int i = 0; i < 10; i++) begin
            d = $random(seed);
            if (sels[i] == SEL_PC) pcv = d;
            wrd(sels[i], 4'h2, SZ_LONG, d, sels[i] == SEL_SR ? d & SR_VALID_MASK : d, 1);
        end
        wrd(SEL_FR, 4'h0, SZ_LONG, v[1], v[1], 1);
        put(3, v[1], 2);
        wrd(SEL_GBR, 4'h0, SZ_LONG, v[2], v[2], 1);
        wrd(SEL_VBR, 4'h0, SZ_LONG, v[3], v[3], 1);
        step();
        gbr_disp_i <= v[4];
        vec_num_i <= 8'hff;
        put(5, v[2] + v[4], 2);
        put(6, v[3] + 32'h000003fc, 2);
        // multiply result wins over a direct write to the high half
        step();
        m = {$random(seed), $random(seed)};
        mac_we_i <= 1'b1;
        mac_result_i <= m;
        wr_i <= '{1'b1, SEL_MAC_HIGH_REG, 4'h0, SZ_LONG, ~m[63:32]};
        step();
        mac_we_i <= 1'b0;
        wr_i.en <= 1'b0;
        rd_a_i <= '{SEL_MAC_HIGH_REG, 4'h0};
        rd_b_i <= '{SEL_MAC_LOW_REG, 4'h0};
        put(0, m[63:32], 2);
        put(1, m[31:0], 2);
        // call beats a return address write, then one step
        step();
        t = $random(seed);
        call_i <= 1'b1;
        call_target_i <= t;
        wr_i <= '{1'b1, SEL_PR, 4'h0, SZ_LONG, ~t};
        step();
        call_i <= 1'b0;
        wr_i.en <= 1'b0;
        pc_step_i <= 1'b1;
        put(7, t, 2);
        step();
        pc_step_i <= 1'b0;
        rd_a_i <= '{SEL_PR, 4'h0};
        put(0, pcv, 2);
        put(7, t + INSN_STEP, 2);
        // push, push with pop and a lost write, then pop
        step();
        exc_push_i <= 1'b1;
        put(4, v[15] - STACK_STEP, 3);
        step();
        exc_pop_i <= 1'b1;
        wr_i <= '{1'b1, SEL_GEN, 4'hf, SZ_LONG, ~v[15]};
        put(4, v[15] - 2 * STACK_STEP, 3);
        step();
        exc_push_i <= 1'b0;
        wr_i.en <= 1'b0;
        put(4, v[15] - STACK_STEP, 3);
        step();
        exc_pop_i <= 1'b0;
        // core to float and back
        step();
        xfer_i <= '{1'b1, 1'b1, 4'h5};
        step();
        xfer_i <= '{1'b1, 1'b0, 4'h9};
        rd_b_i <= '{SEL_FLOAT_TRANSFER_REG, 4'h0};
        put(1, v[5], 2);
        step();
        xfer_i.en <= 1'b0;
        rd_a_i <= '{SEL_GEN, 4'h9};
        put(0, v[5], 2);
        // exception flags stick over a simultaneous write
        step();
        f = 5'($random(seed)) | 5'h01;
        d = $random(seed);
        fpu_flags_i <= f;
        wr_i <= '{1'b1, SEL_FLOAT_STATUS_CONTROL_REG, 4'h0, SZ_LONG, d};
        put(9, d | {25'h0, f, 2'b00}, 3);
        step();
        fpu_flags_i <= '0;
        wr_i.en <= 1'b0;
        step();
        step();
        put(9, d | {25'h0, f, 2'b00}, 2);
        // let the sticky-flag check land before reset clears the taps
        repeat (2) step();
        // second reset in mid-run
        do_reset();
        fetch(32'h00002468, 32'h0000ff00);
        repeat (6) step();
        if (q.size() != 0) begin
            bad_count++;
            $display("BAD %0t results never seen %0d", $time, q.size());
        end
        test_done();
    end
endmodule
`default_nettype wire
